//--- rtl/mscif_pkg.sv
package mscif_pkg;

  localparam logic [7:0] CMD_SYS_RESET = 8'h01;
  localparam logic [7:0] CMD_PORT_DIR = 8'h02;
  localparam logic [7:0] CMD_PORT_OUT = 8'h03;
  localparam logic [7:0] CMD_PORT_IN = 8'h04;
  localparam logic [7:0] CMD_TX_WRITE = 8'h07;
  localparam logic [7:0] CMD_STATUS = 8'h0a;
  localparam logic [7:0] CMD_SEND_BIT = 8'h0b;
  localparam logic [7:0] CMD_SEND_OOB = 8'h0c;
  localparam logic [7:0] CMD_SEND = 8'h0d;
  localparam logic [7:0] CMD_SEND_RECV = 8'h0e;
  localparam logic [7:0] CMD_GET_KEY = 8'h0f;
  localparam logic [7:0] CMD_RX_READ = 8'h10;
  localparam logic [7:0] CMD_STORE_CONF = 8'h11;
  localparam logic [7:0] CMD_GET_ID = 8'h12;
  localparam logic [7:0] CMD_MEASURE = 8'h14;
  localparam logic [7:0] CMD_TEST_MODE = 8'h15;
  localparam logic [7:0] CMD_STORE_FREQ = 8'h1a;
  localparam logic [7:0] CMD_TEST_TX_FREQ = 8'h1b;
  localparam logic [7:0] CMD_TEST_RX_FREQ = 8'h1c;
  localparam logic [7:0] CMD_STORE_XTAL = 8'h1d;
  localparam logic [7:0] CMD_READ_XTAL = 8'h1e;
  localparam logic [7:0] CMD_READ_CONF = 8'h1f;
  localparam logic [7:0] CMD_READ_BUF = 8'h20;
  localparam logic [7:0] CMD_STORE_CHAN = 8'h22;
  localparam logic [7:0] CMD_RSSI_ADJ = 8'h24;
  localparam logic [7:0] CMD_READ_CHAN = 8'h25;

  localparam int TX_BUF_BYTES = 12;
  localparam int RX_BUF_BYTES = 8;
  localparam int XTAL_ENTRIES = 23;
  localparam int XTAL_READ_FIRST = 2;
  localparam int XTAL_READ_COUNT = 16;
  localparam int CHAN_BYTES = 14;
  localparam int RD_BUF_BYTES = 16;
  localparam int PORT_PINS = 5;

  localparam logic [7:0] SYSTEM_CONFIG_BYTE_RESET = 8'h3d;
  localparam int CFG_SUPPLY_BIT = 3;
  localparam int CFG_UPLINK_ONLY_BIT = 2;
  localparam int CFG_REGION_BIT = 1;

  // Arbitrary identity values
  localparam logic [127:0] KEY_VALUE = 128'h00112233445566778899aabbccddeeff;
  localparam logic [31:0] ID_VALUE = 32'h0000abcd;

  localparam int SYS_CLK_NS = 25;
  localparam int UPLINK_TIME_NS = 2000;
  localparam int DOWNLINK_TIME_NS = 3000;
  localparam int MEASURE_TIME_NS = 500;
  localparam logic [15:0] UPLINK_CYCLES = 16'((UPLINK_TIME_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
  localparam logic [15:0] DOWNLINK_CYCLES = 16'(DOWNLINK_TIME_NS / SYS_CLK_NS);
  localparam logic [15:0] MEASURE_CYCLES = 16'((MEASURE_TIME_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);

  typedef enum logic [1:0] {
    MSCIF_RF_IDLE = 2'b00,
    MSCIF_RF_UP = 2'b01,
    MSCIF_RF_DOWN = 2'b10,
    MSCIF_RF_MEAS = 2'b11
  } mscif_rf_t;

  typedef struct packed {
    logic enable;
    logic direction;
  } mscif_fe_t;

  typedef struct packed {
    logic tx_path;
    logic rx_path;
  } mscif_ant_t;

endpackage : mscif_pkg

//--- rtl/mscif_top.sv
`timescale 1ns/10ps
module mscif_top (
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic CE,
  input wire logic SPI_SCK,
  input wire logic SPI_NSS_N,
  input wire logic SPI_MOSI,
  output logic SPI_MISO,
  input wire logic [4:0] PORT_C_IN,
  output logic [4:0] PORT_C_OUT,
  output logic [4:0] PORT_C_OE_N,
  input wire logic [7:0] RF_RX_BYTE,
  input wire logic RF_RX_VALID,
  input wire logic [7:0] RF_RSSI,
  output logic COMPLETION_EVENT_N,
  output mscif_pkg::mscif_fe_t FRONT_END,
  output mscif_pkg::mscif_ant_t ANT_SWITCH,
  output logic [7:0] SYSTEM_RSSI,
  output logic [7:0] SYSTEM_CONFIG,
  output logic [31:0] UPLINK_FREQ,
  output logic [31:0] DOWNLINK_FREQ
);

  // ********************************
  // Link side, clocked by the host
  // ********************************
  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] rx_byte;
    logic tog;
    logic [7:0] out_shift;
  } mscif_link_t;

  mscif_link_t l, next_l;
  logic [7:0] tx_byte;

  always_comb begin
    next_l = l;
    next_l.bit_cnt = 3'(l.bit_cnt + 3'h1);
    next_l.shreg = {l.shreg[6:0], SPI_MOSI};
    next_l.out_shift = {l.out_shift[6:0], 1'b0};
    if (l.bit_cnt == 3'h0) begin
      next_l.out_shift = {tx_byte[6:0], 1'b0};
    end
    if (l.bit_cnt == 3'h7) begin
      next_l.rx_byte = {l.shreg[6:0], SPI_MOSI};
      next_l.tog = ~l.tog;
    end
  end

  // Deselect clears the link side; the clock stands still between frames
  always_ff @(posedge SPI_SCK or posedge SPI_NSS_N) begin
    if (SPI_NSS_N) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  assign SPI_MISO = (l.bit_cnt == 3'h0) ? tx_byte[7] : l.out_shift[7];

  // ********************************
  // System side state
  // ********************************
  typedef struct packed {
    logic nss_s1;
    logic nss_s2;
    logic tog_s1;
    logic tog_s2;
    logic tog_seen;
    logic [4:0] pin_s1;
    logic [4:0] pin_s2;
    logic [4:0] byte_idx;
    logic [7:0] cmd;
    logic [7:0] tx_byte;
    logic [4:0] dir;
    logic [4:0] out;
    logic [11:0][7:0] tx_buf;
    logic [7:0][7:0] rx_buf;
    logic [31:0] test_up;
    logic [31:0] test_dn;
    logic test_up_set;
    logic test_dn_set;
    logic [4:0] st_dir;
    logic [4:0] st_out;
    logic [7:0] repeat_cnt;
    logic [7:0] system_config_byte;
    logic [31:0] freq_up;
    logic [31:0] freq_dn;
    logic [22:0][7:0] xtal;
    logic [4:0] xtal_idx;
    logic [13:0][7:0] chan;
    logic [7:0] rssi_ofs;
    logic [7:0] rssi_sys;
    logic [15:0][7:0] rd_buf;
    logic [7:0] active_conf;
    logic freq_ok;
    logic conf_ok;
    logic cfg_valid;
    logic rejected;
    logic event_n;
    mscif_pkg::mscif_rf_t rf;
    logic down_next;
    logic [15:0] timer;
    logic [2:0] rx_wr;
  } mscif_sys_t;

  mscif_sys_t r, next_r;
  logic byte_ev;
  logic [7:0] b;
  logic [4:0] k;
  logic done;
  logic start_up;
  logic rf_cmd;

  assign tx_byte = r.tx_byte;
  assign b = l.rx_byte;
  assign k = 5'(r.byte_idx - 5'h1);
  assign byte_ev = (r.tog_s2 != r.tog_seen) && !r.nss_s2;

  function automatic logic [7:0] resp(input mscif_sys_t s, input logic [7:0] c,
                                       input logic [4:0] n);
    logic [4:0] d;
    d = 5'(n - 5'h1);
    resp = 8'h00;
    if (n != 5'h0) begin
      case (c)
        mscif_pkg::CMD_PORT_IN: resp = (d == 5'h0) ? {2'b00, s.pin_s2, 1'b0} : 8'h00;
        mscif_pkg::CMD_STATUS: resp = (d == 5'h0) ? {5'h00, s.rejected, s.cfg_valid,
                                                     s.rf != mscif_pkg::MSCIF_RF_IDLE} : 8'h00;
        mscif_pkg::CMD_GET_KEY: resp = (d < 5'd16) ? s.rd_buf[0] & 8'h00 |
                                       mscif_pkg::KEY_VALUE[8'(127 - 8 * d) -: 8] : 8'h00;
        mscif_pkg::CMD_GET_ID: resp = (d < 5'd4) ? mscif_pkg::ID_VALUE[8'(31 - 8 * d) -: 8]
                                                 : 8'h00;
        mscif_pkg::CMD_RX_READ: resp = (d < 5'd8) ? s.rx_buf[d[2:0]] : 8'h00;
        mscif_pkg::CMD_READ_BUF: resp = (d < 5'd16) ? s.rd_buf[d[3:0]] : 8'h00;
        default: resp = 8'h00;
      endcase
    end
  endfunction : resp

  // ********************************
  // System side next state
  // ********************************
  always_comb begin
    next_r = r;
    done = 1'b0;
    start_up = 1'b0;
    rf_cmd = 1'b0;
    next_r.nss_s1 = SPI_NSS_N;
    next_r.nss_s2 = r.nss_s1;
    next_r.tog_s1 = l.tog;
    next_r.tog_s2 = r.tog_s1;
    next_r.pin_s1 = PORT_C_IN;
    next_r.pin_s2 = r.pin_s1;
    next_r.rssi_sys = 8'(RF_RSSI + r.rssi_ofs);
    if (r.nss_s2) begin
      next_r.byte_idx = 5'h0;
      next_r.tog_seen = 1'b0;
      next_r.tx_byte = 8'h00;
    end else if (byte_ev) begin
      next_r.tog_seen = r.tog_s2;
      if (r.byte_idx != 5'h1f) begin
        next_r.byte_idx = 5'(r.byte_idx + 5'h1);
      end
      if (r.byte_idx == 5'h0) begin
        next_r.cmd = b;
        case (b)
          mscif_pkg::CMD_SYS_RESET: begin
            next_r.active_conf = r.system_config_byte;
            next_r.cfg_valid = r.freq_ok && r.conf_ok;
            next_r.dir = r.st_dir;
            next_r.out = r.st_out;
            next_r.test_up_set = 1'b0;
            next_r.test_dn_set = 1'b0;
            next_r.rf = mscif_pkg::MSCIF_RF_IDLE;
            done = 1'b1;
          end
          mscif_pkg::CMD_SEND, mscif_pkg::CMD_SEND_RECV, mscif_pkg::CMD_SEND_BIT,
          mscif_pkg::CMD_SEND_OOB, mscif_pkg::CMD_TEST_MODE: begin
            rf_cmd = 1'b1;
          end
          mscif_pkg::CMD_MEASURE: begin
            if (r.rf == mscif_pkg::MSCIF_RF_IDLE) begin
              next_r.rf = mscif_pkg::MSCIF_RF_MEAS;
              next_r.timer = mscif_pkg::MEASURE_CYCLES;
            end
          end
          mscif_pkg::CMD_READ_XTAL: begin
            for (int i = 0; i < mscif_pkg::XTAL_READ_COUNT; i++) begin
              next_r.rd_buf[i] = r.xtal[i + mscif_pkg::XTAL_READ_FIRST];
            end
          end
          mscif_pkg::CMD_READ_CONF: begin
            // repeat count sits after the two frequencies
            next_r.rd_buf = '0;
            for (int i = 0; i < 4; i++) begin
              next_r.rd_buf[i] = r.freq_up[8 * i +: 8];
              next_r.rd_buf[i + 4] = r.freq_dn[8 * i +: 8];
            end
            next_r.rd_buf[8] = r.repeat_cnt;
            next_r.rd_buf[9] = r.system_config_byte;
          end
          mscif_pkg::CMD_READ_CHAN: begin
            next_r.rd_buf = '0;
            for (int i = 0; i < mscif_pkg::CHAN_BYTES; i++) begin
              next_r.rd_buf[i] = r.chan[i];
            end
          end
          default: begin
          end
        endcase
      end else begin
        case (r.cmd)
          mscif_pkg::CMD_PORT_DIR: if (k == 5'h0) next_r.dir = b[5:1];
          mscif_pkg::CMD_PORT_OUT: if (k == 5'h0) next_r.out = b[5:1];
          mscif_pkg::CMD_TX_WRITE: begin
            if (k < 5'(mscif_pkg::TX_BUF_BYTES)) begin
              next_r.tx_buf[k[3:0]] = b;
            end
          end
          mscif_pkg::CMD_STORE_CONF: begin
            case (k)
              5'h0: next_r.st_dir = b[5:1];
              5'h1: next_r.st_out = b[5:1];
              5'h2: next_r.repeat_cnt = b;
              5'h3: begin
                next_r.system_config_byte = b;
                next_r.conf_ok = 1'b1;
                done = 1'b1;
              end
              default: begin
              end
            endcase
          end
          mscif_pkg::CMD_STORE_FREQ: begin
            if (k < 5'h4) begin
              next_r.freq_up[8 * k[1:0] +: 8] = b;
            end else if (k < 5'h8) begin
              next_r.freq_dn[8 * k[1:0] +: 8] = b;
            end
            if (k == 5'h7) begin
              next_r.freq_ok = 1'b1;
              done = 1'b1;
            end
          end
          mscif_pkg::CMD_TEST_TX_FREQ: begin
            if (k < 5'h4) begin
              next_r.test_up[8 * (2'h3 - k[1:0]) +: 8] = b;
              next_r.test_up_set = (k == 5'h3) || r.test_up_set;
            end
          end
          mscif_pkg::CMD_TEST_RX_FREQ: begin
            if (k < 5'h4) begin
              next_r.test_dn[8 * (2'h3 - k[1:0]) +: 8] = b;
              next_r.test_dn_set = (k == 5'h3) || r.test_dn_set;
            end
          end
          mscif_pkg::CMD_STORE_XTAL: begin
            if (k == 5'h0) begin
              next_r.xtal_idx = b[4:0];
            end else if (k == 5'h1) begin
              if (r.xtal_idx < 5'(mscif_pkg::XTAL_ENTRIES)) begin
                next_r.xtal[r.xtal_idx] = b;
              end
              done = 1'b1;
            end
          end
          mscif_pkg::CMD_STORE_CHAN: begin
            if (k < 5'(mscif_pkg::CHAN_BYTES)) begin
              next_r.chan[k[3:0]] = b;
            end
            if (k == 5'(mscif_pkg::CHAN_BYTES - 1)) begin
              done = 1'b1;
            end
          end
          mscif_pkg::CMD_RSSI_ADJ: begin
            if (k == 5'h0) begin
              next_r.rssi_ofs = b;
              done = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
      next_r.tx_byte = resp(r, (r.byte_idx == 5'h0) ? b : r.cmd, next_r.byte_idx);
    end

    if (rf_cmd) begin
      if (!r.cfg_valid || r.rf != mscif_pkg::MSCIF_RF_IDLE) begin
        next_r.rejected = 1'b1;
      end else begin
        next_r.rejected = 1'b0;
        start_up = 1'b1;
        next_r.down_next = (b == mscif_pkg::CMD_SEND_RECV) &&
                           !r.active_conf[mscif_pkg::CFG_UPLINK_ONLY_BIT];
      end
    end

    case (r.rf)
      mscif_pkg::MSCIF_RF_IDLE: begin
        if (start_up) begin
          next_r.rf = mscif_pkg::MSCIF_RF_UP;
          next_r.timer = mscif_pkg::UPLINK_CYCLES;
        end
      end
      mscif_pkg::MSCIF_RF_UP: begin
        next_r.timer = 16'(r.timer - 16'h1);
        if (r.timer == 16'h1) begin
          if (r.down_next) begin
            next_r.rf = mscif_pkg::MSCIF_RF_DOWN;
            next_r.timer = mscif_pkg::DOWNLINK_CYCLES;
            next_r.rx_wr = 3'h0;
          end else begin
            next_r.rf = mscif_pkg::MSCIF_RF_IDLE;
            done = 1'b1;
          end
        end
      end
      mscif_pkg::MSCIF_RF_DOWN: begin
        next_r.timer = 16'(r.timer - 16'h1);
        // payload then raw RSSI in last byte
        if (RF_RX_VALID && r.rx_wr != 3'h7) begin
          next_r.rx_buf[r.rx_wr] = RF_RX_BYTE;
          next_r.rx_wr = 3'(r.rx_wr + 3'h1);
        end
        if (r.timer == 16'h1) begin
          next_r.rx_buf[mscif_pkg::RX_BUF_BYTES - 1] = RF_RSSI;
          next_r.rf = mscif_pkg::MSCIF_RF_IDLE;
          done = 1'b1;
        end
      end
      mscif_pkg::MSCIF_RF_MEAS: begin
        next_r.timer = 16'(r.timer - 16'h1);
        if (r.timer == 16'h1) begin
          next_r.rf = mscif_pkg::MSCIF_RF_IDLE;
          done = 1'b1;
        end
      end
      default: next_r.rf = mscif_pkg::MSCIF_RF_IDLE;
    endcase

    // status read releases, a completion in the same cycle wins
    if (byte_ev && r.byte_idx == 5'h0 && b == mscif_pkg::CMD_STATUS) begin
      next_r.event_n = 1'b1;
    end
    if (done) begin
      next_r.event_n = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      r <= '0;
      r.nss_s1 <= 1'b1;
      r.nss_s2 <= 1'b1;
      r.system_config_byte <= mscif_pkg::SYSTEM_CONFIG_BYTE_RESET;
      r.active_conf <= mscif_pkg::SYSTEM_CONFIG_BYTE_RESET;
      r.event_n <= 1'b1;
      r.rf <= mscif_pkg::MSCIF_RF_IDLE;
    end else if (CE) begin
      r <= next_r;
    end
  end

  // ********************************
  // Pins
  // ********************************
  genvar gi;
  generate
    for (gi = 0; gi < mscif_pkg::PORT_PINS; gi++) begin : g_port
      // a set direction bit drives the pin
      assign PORT_C_OE_N[gi] = ~r.dir[gi];
      assign PORT_C_OUT[gi] = r.out[gi];
    end
  endgenerate

  assign FRONT_END.enable = (r.rf == mscif_pkg::MSCIF_RF_UP) || (r.rf == mscif_pkg::MSCIF_RF_DOWN);
  assign FRONT_END.direction = (r.rf == mscif_pkg::MSCIF_RF_UP);
  assign ANT_SWITCH.tx_path = (r.rf == mscif_pkg::MSCIF_RF_UP);
  assign ANT_SWITCH.rx_path = (r.rf == mscif_pkg::MSCIF_RF_DOWN);
  assign COMPLETION_EVENT_N = r.event_n;
  assign SYSTEM_RSSI = r.rssi_sys;
  assign SYSTEM_CONFIG = r.active_conf;
  assign UPLINK_FREQ = r.test_up_set ? r.test_up : r.freq_up;
  assign DOWNLINK_FREQ = r.test_dn_set ? r.test_dn : r.freq_dn;

  // ********************************
  // Checks
  // ********************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  evt_release_a: assert property (
    CE && byte_ev && r.byte_idx == 5'h0 && b == mscif_pkg::CMD_STATUS && !done
    |=> COMPLETION_EVENT_N) else $error("status read did not release event");
  evt_set_a: assert property (
    CE && done |=> !COMPLETION_EVENT_N) else $error("completion did not raise event");
  rf_refuse_a: assert property (
    CE && rf_cmd && !r.cfg_valid && r.rf == mscif_pkg::MSCIF_RF_IDLE
    |=> !FRONT_END.enable && r.rejected) else $error("RF command ran unconfigured");
  fe_uplink_a: assert property (
    CE && start_up |=> (FRONT_END.enable && FRONT_END.direction) [*3])
    else $error("front end not in uplink");
  ant_path_a: assert property (
    FRONT_END.enable |-> (ANT_SWITCH.tx_path == FRONT_END.direction) &&
    (ANT_SWITCH.rx_path == !FRONT_END.direction)) else $error("antenna path wrong");
  rssi_sum_a: assert property (
    CE |=> SYSTEM_RSSI == 8'($past(RF_RSSI) + $past(r.rssi_ofs)))
    else $error("corrected RSSI wrong");
  txbuf_store_a: assert property (
    CE && byte_ev && r.byte_idx != 5'h0 && r.cmd == mscif_pkg::CMD_TX_WRITE && k < 5'd12
    |=> r.tx_buf[$past(k[3:0])] == $past(b)) else $error("TX buffer byte lost");
  conf_apply_a: assert property (
    CE && byte_ev && r.byte_idx == 5'h0 && b == mscif_pkg::CMD_SYS_RESET
    |=> SYSTEM_CONFIG == $past(r.system_config_byte)) else $error("config not applied at reset");
  port_dir_a: assert property (
    CE && byte_ev && r.byte_idx != 5'h0 && r.cmd == mscif_pkg::CMD_PORT_DIR && k == 5'h0
    |=> PORT_C_OE_N == ~$past(b[5:1])) else $error("port direction mismatch");
  uplink_len_a: assert property (
    CE && start_up |=> FRONT_END.enable [*8]) else $error("uplink ended early");

endmodule : mscif_top

//--- sim/mscif_bench.sv
`timescale 1ns/10ps
`define CHK(w, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s expected %h seen %h", w, e, g); end end
// ****
// Bench top
// ****
module mscif_bench;
  logic SYS_CLK = 1'b0;
  logic SRST, CE, SPI_SCK, SPI_NSS_N, SPI_MOSI, SPI_MISO, RF_RX_VALID, COMPLETION_EVENT_N;
  logic [4:0] PORT_C_IN, PORT_C_OUT, PORT_C_OE_N;
  logic [7:0] RF_RX_BYTE, RF_RSSI, SYSTEM_RSSI, SYSTEM_CONFIG, rs, off, d, o;
  logic [31:0] UPLINK_FREQ, DOWNLINK_FREQ;
  mscif_pkg::mscif_fe_t FRONT_END;
  mscif_pkg::mscif_ant_t ANT_SWITCH;
  logic [7:0] p [0:31];
  logic [7:0] r [0:31];
  logic [7:0] rf [0:4] = '{8'h0d, 8'h0e, 8'h0b, 8'h0c, 8'h15};
  logic [7:0] exp_q [$];
  logic [79:0] cf;
  int n_mismatch = 0;
  int checked = 0;
  always #12.5 SYS_CLK = ~SYS_CLK;
  mscif_top u_mscif_top (.SYS_CLK(SYS_CLK), .SRST(SRST), .CE(CE), .SPI_SCK(SPI_SCK),
    .SPI_NSS_N(SPI_NSS_N), .SPI_MOSI(SPI_MOSI), .SPI_MISO(SPI_MISO), .PORT_C_IN(PORT_C_IN),
    .PORT_C_OUT(PORT_C_OUT), .PORT_C_OE_N(PORT_C_OE_N), .RF_RX_BYTE(RF_RX_BYTE),
    .RF_RX_VALID(RF_RX_VALID), .RF_RSSI(RF_RSSI), .COMPLETION_EVENT_N(COMPLETION_EVENT_N),
    .FRONT_END(FRONT_END), .ANT_SWITCH(ANT_SWITCH), .SYSTEM_RSSI(SYSTEM_RSSI),
    .SYSTEM_CONFIG(SYSTEM_CONFIG), .UPLINK_FREQ(UPLINK_FREQ), .DOWNLINK_FREQ(DOWNLINK_FREQ));
  mscif_host u_mscif_host (.spi_sck(SPI_SCK), .spi_nss_n(SPI_NSS_N), .spi_mosi(SPI_MOSI),
    .spi_miso(SPI_MISO));
  // ****
  // Tasks
  // ****
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic tmo(input string w);
    n_mismatch++;
    $display("BAD %s expected done seen timeout", w);
    print_verdict();
  endtask : tmo
  task automatic cmd(input logic [7:0] c, input int n);
    u_mscif_host.tx[0] = c;
    for (int i = 0; i < n; i++) u_mscif_host.tx[i + 1] = p[i];
    u_mscif_host.frame(n + 1);
    for (int i = 0; i < n; i++) r[i] = u_mscif_host.rx[i + 1];
  endtask : cmd
  task automatic cmp_q(input string w);
    logic [7:0] e;
    for (int i = 0; exp_q.size() > 0; i++) begin
      e = exp_q.pop_front();
      `CHK(w, e, r[i])
    end
  endtask : cmp_q
  task automatic wait_evt(input int bound);
    int k;
    for (k = 0; k < bound && COMPLETION_EVENT_N !== 1'b0; k++) @(negedge SYS_CLK);
    if (k == bound) tmo("event");
    cmd(mscif_pkg::CMD_STATUS, 1);
    `CHK("event release", 1'b1, COMPLETION_EVENT_N)
  endtask : wait_evt
  task automatic wait_fe(input logic [1:0] f);
    int k;
    for (k = 0; k < 300 && FRONT_END !== f; k++) @(negedge SYS_CLK);
    if (k == 300) tmo("front end");
  endtask : wait_fe
  // ****
  // Main sequence
  // ****
  initial begin
    CE = 1'b1;
    SRST = 1'b1;
    PORT_C_IN = 5'h00;
    RF_RX_BYTE = 8'h00;
    RF_RX_VALID = 1'b0;
    RF_RSSI = 8'h00;
    void'($urandom(77));
    repeat (8) @(negedge SYS_CLK);
    SRST = 1'b0;
    repeat (4) @(negedge SYS_CLK);
    `CHK("reset config", 8'h3d, SYSTEM_CONFIG)
    `CHK("reset event", 1'b1, COMPLETION_EVENT_N)
    `CHK("reset front end", 2'b00, FRONT_END)
    $display("test reset done");
    d = 8'($urandom);
    o = 8'($urandom);
    p[0] = d;
    cmd(mscif_pkg::CMD_PORT_DIR, 1);
    p[0] = o;
    cmd(mscif_pkg::CMD_PORT_OUT, 1);
    @(negedge SYS_CLK) PORT_C_IN = d[4:0] ^ o[4:0];
    repeat (4) @(negedge SYS_CLK);
    cmd(mscif_pkg::CMD_PORT_IN, 1);
    `CHK("port oe", ~d[5:1], PORT_C_OE_N)
    `CHK("port out", o[5:1], PORT_C_OUT)
    `CHK("port in", 8'(PORT_C_IN) << 1, r[0])
    $display("test port done");
    off = 8'($urandom);
    p[0] = off;
    cmd(mscif_pkg::CMD_RSSI_ADJ, 1);
    wait_evt(50);
    rs = 8'($urandom);
    @(negedge SYS_CLK) RF_RSSI = rs;
    repeat (3) @(negedge SYS_CLK);
    `CHK("system rssi", 8'(rs + off), SYSTEM_RSSI)
    // Enable low must freeze the corrected level
    CE = 1'b0;
    RF_RSSI = ~rs;
    repeat (3) @(negedge SYS_CLK);
    `CHK("rssi frozen", 8'(rs + off), SYSTEM_RSSI)
    CE = 1'b1;
    foreach (rf[i]) begin
      cmd(rf[i], 0);
      repeat (20) @(negedge SYS_CLK);
      `CHK("refused front end", 2'b00, FRONT_END)
      cmd(mscif_pkg::CMD_STATUS, 1);
      `CHK("refused flag", 1'b1, r[0][2])
    end
    $display("test rssi and refusal done");
    // Region byte: uplink and downlink, EU, 3 V supply
    cf = {8'h3b, 8'h02, 32'h33d3e608, 32'h33be9cd0};
    for (int i = 0; i < 8; i++) p[i] = cf[8 * i +: 8];
    cmd(mscif_pkg::CMD_STORE_FREQ, 8);
    wait_evt(50);
    p[0] = d;
    p[1] = o;
    p[2] = cf[71:64];
    p[3] = cf[79:72];
    cmd(mscif_pkg::CMD_STORE_CONF, 4);
    wait_evt(50);
    `CHK("config before reset", 8'h3d, SYSTEM_CONFIG)
    cmd(mscif_pkg::CMD_SYS_RESET, 0);
    wait_evt(50);
    `CHK("config applied", cf[79:72], SYSTEM_CONFIG)
    `CHK("uplink freq", cf[31:0], UPLINK_FREQ)
    `CHK("downlink freq", cf[63:32], DOWNLINK_FREQ)
    cmd(8'h23, 0);
    cmd(mscif_pkg::CMD_READ_CONF, 0);
    for (int i = 0; i < 10; i++) exp_q.push_back(cf[8 * i +: 8]);
    cmd(mscif_pkg::CMD_READ_BUF, 16);
    cmp_q("config readback");
    $display("test config done");
    for (int i = 0; i < 8; i++) p[i] = 8'($urandom);
    // Test frequencies arrive most significant byte first
    cmd(mscif_pkg::CMD_TEST_TX_FREQ, 4);
    `CHK("test uplink freq", {p[0], p[1], p[2], p[3]}, UPLINK_FREQ)
    for (int i = 0; i < 4; i++) p[i] = p[i + 4];
    cmd(mscif_pkg::CMD_TEST_RX_FREQ, 4);
    `CHK("test downlink freq", {p[0], p[1], p[2], p[3]}, DOWNLINK_FREQ)
    for (int i = 0; i < 12; i++) p[i] = 8'($urandom);
    cmd(mscif_pkg::CMD_TX_WRITE, 12);
    cmd(mscif_pkg::CMD_SEND_RECV, 0);
    wait_fe(2'b11);
    `CHK("uplink antenna", 2'b10, ANT_SWITCH)
    wait_fe(2'b10);
    `CHK("downlink antenna", 2'b01, ANT_SWITCH)
    rs = 8'($urandom);
    for (int i = 0; i < 7; i++) begin
      exp_q.push_back(8'($urandom));
      @(negedge SYS_CLK);
      RF_RX_BYTE = exp_q[i];
      RF_RX_VALID = 1'b1;
      RF_RSSI = rs;
      @(negedge SYS_CLK) RF_RX_VALID = 1'b0;
    end
    exp_q.push_back(rs);
    wait_evt(400);
    `CHK("idle front end", 2'b00, FRONT_END)
    cmd(mscif_pkg::CMD_RX_READ, 8);
    cmp_q("rx buffer");
    cmd(mscif_pkg::CMD_MEASURE, 0);
    `CHK("measure front end", 2'b00, FRONT_END)
    wait_evt(100);
    $display("test send receive done");
    for (int i = 0; i < 23; i++) begin
      p[0] = 8'(i);
      p[1] = 8'($urandom);
      if (i >= 2 && i < 18) exp_q.push_back(p[1]);
      cmd(mscif_pkg::CMD_STORE_XTAL, 2);
      wait_evt(50);
    end
    cmd(mscif_pkg::CMD_READ_XTAL, 0);
    cmd(mscif_pkg::CMD_READ_BUF, 16);
    cmp_q("crystal table");
    u_mscif_host.gap_ns = 600;
    for (int i = 0; i < 14; i++) begin
      p[i] = 8'($urandom);
      exp_q.push_back(p[i]);
    end
    cmd(mscif_pkg::CMD_STORE_CHAN, 14);
    wait_evt(50);
    // table stored, reset, then usage reset
    cmd(mscif_pkg::CMD_SYS_RESET, 0);
    wait_evt(50);
    // usage reset once after this reset
    cmd(8'h23, 0);
    `CHK("stored uplink freq", cf[31:0], UPLINK_FREQ)
    `CHK("stored downlink freq", cf[63:32], DOWNLINK_FREQ)
    cmd(mscif_pkg::CMD_READ_CHAN, 0);
    cmd(mscif_pkg::CMD_READ_BUF, 16);
    cmp_q("channel table");
    u_mscif_host.gap_ns = 225;
    $display("test tables done");
    for (int i = 0; i < 16; i++) exp_q.push_back(mscif_pkg::KEY_VALUE[127 - 8 * i -: 8]);
    cmd(mscif_pkg::CMD_GET_KEY, 16);
    cmp_q("key");
    for (int i = 0; i < 4; i++) exp_q.push_back(mscif_pkg::ID_VALUE[31 - 8 * i -: 8]);
    cmd(mscif_pkg::CMD_GET_ID, 4);
    cmp_q("identifier");
    $display("test identity done");
    print_verdict();
  end
endmodule : mscif_bench

//--- sim/mscif_host.sv
`timescale 1ns/10ps
// ****
// Host master model
// ****
module mscif_host (
  output logic spi_sck,
  output logic spi_nss_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  logic [7:0] tx [0:31];
  logic [7:0] rx [0:31];
  // Byte spacing; a wide value plays a slow host
  int gap_ns = 225;
  initial begin
    spi_sck = 1'b0;
    spi_nss_n = 1'b1;
    spi_mosi = 1'b1;
  end
  task automatic frame(input int n);
    spi_nss_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      for (int b = 7; b >= 0; b--) begin
        spi_mosi = tx[i][b];
        #3;
        rx[i][b] = spi_miso;
        spi_sck = 1'b1;
        #3;
        spi_sck = 1'b0;
      end
      #(gap_ns);
    end
    // Released line shows the inverse so a stale bit is never trusted
    spi_mosi = ~spi_mosi;
    spi_nss_n = 1'b1;
    #150;
  endtask : frame
endmodule : mscif_host
